//--- verilog/iopa_top.sv
// I/O ports with programmable pin assignment, port data registers and fixed mappings.
// Assumes pads outside resolve drive and pulls; peripherals run on clk_sys_i.
// How it works
// - Four ports of 8, 6, 10 and 1 to 8 pins.
// - Five-bit code in each pin's mode picks the peripheral signal routed there.
// - Code zero hands the pin to the port data, set and clear registers.
// - A peripheral input fed by several pins takes the lowest numbered one.
// - Mode bits nine and eight pick float, pull-up, pull-down input or output.
// - Pulls are off in output mode and analog mode.
// - Data read returns live pin levels, zero for analog pins.
// - Pin level read and output data write share one address.
// - Data write stores the values driven on general purpose outputs.
// - Set register ones drive outputs high, zeros change nothing.
// - Clear register ones drive outputs low, zeros change nothing.
// - Port 0 bits 0 to 3 are analog inputs chosen by code.
// - Port 1 bits 4 and 5 carry debug clock and data when enabled.
// - Decoder pin choice overrides the multiplexer for decoder inputs.
// - In sleep the pins can hold their last driven state.
`timescale 1ns/1ps
module iopa_top #(
	parameter int P3_W = iopa_pkg::PORT3_W
) (
	input  wire logic                          clk_sys_i,
	input  wire logic                          sys_rst_i,
	input  wire logic [11:0]                   addr_i,
	input  wire logic [31:0]                   wdata_i,
	input  wire logic                          wr_i,
	input  wire logic                          rd_i,
	output logic      [31:0]                   rdata_o,
	input  wire logic [24+P3_W-1:0]            pad_in_i,
	output logic      [24+P3_W-1:0]            pad_out_o,
	output logic      [24+P3_W-1:0]            pad_oe_o,
	output logic      [24+P3_W-1:0]            pull_up_o,
	output logic      [24+P3_W-1:0]            pull_down_o,
	output logic      [24+P3_W-1:0]            analog_en_o,
	input  wire logic [31:0]                   periph_out_i,
	output logic      [31:0]                   periph_in_o,
	input  wire logic                          sleep_i,
	input  wire logic                          debug_data_out_i,
	input  wire logic                          debug_data_oe_i,
	output logic                               debug_serial_clock_o,
	output logic                               debug_data_in_o,
	output logic      [2:0]                    quad_a_o,
	output logic      [2:0]                    quad_b_o
);
	localparam int NPIN = 24 + P3_W;

	typedef struct packed {
		logic [NPIN-1:0]        sync1;
		logic [NPIN-1:0]        sync2;
		logic [NPIN-1:0][9:0]   mode;
		logic [3:0][9:0]        odata;
		logic                   dbg_en;
		logic                   hold_en;
		logic [11:0]            qsel;
		logic [31:0]            rdata;
		logic [NPIN-1:0]        pad_out;
		logic [NPIN-1:0]        pad_oe;
		logic [NPIN-1:0]        pu;
		logic [NPIN-1:0]        pd;
		logic [NPIN-1:0]        ana;
		logic [31:0]            pin_in;
		logic                   dbg_clk;
		logic                   dbg_din;
		logic [2:0]             qa;
		logic [2:0]             qb;
	} iopa_state_t;

	iopa_state_t r;
	iopa_state_t next_r;

	logic [NPIN-1:0] cell_drive;
	logic [NPIN-1:0] cell_oe;
	logic [NPIN-1:0] cell_pu;
	logic [NPIN-1:0] cell_pd;
	logic [NPIN-1:0] cell_ana;
	logic [NPIN-1:0] cell_gpio;

	// port widths
	// Width of port p in pins.
	function automatic int port_width(input int p);
		case (p)
			0:       return iopa_pkg::PORT0_W;
			1:       return iopa_pkg::PORT1_W;
			2:       return iopa_pkg::PORT2_W;
			default: return P3_W;
		endcase
	endfunction

	// Port of a flat pin index.
	function automatic int pin_port(input int i);
		int p;
		p = 0;
		for (int k = 1; k < iopa_pkg::NPORT; k++) begin
			if (i >= iopa_pkg::port_base(k)) begin
				p = k;
			end
		end
		return p;
	endfunction

	// True when the address selects the mode register of an existing pin.
	function automatic logic is_mode_addr(input logic [11:0] a);
		logic hit;
		hit = (a[11:8] == iopa_pkg::MODE_BASE[11:8]) && (a[1:0] == 2'h0);
		return hit && (int'(a[7:2]) < NPIN);
	endfunction

	// True when the address lies in the window of the four port registers.
	function automatic logic is_port_addr(input logic [11:0] a);
		return (a[11:8] == iopa_pkg::PORT_BASE[11:8]) && (a[7:6] == 2'h0);
	endfunction

	// Mask of the bits that exist in port p.
	function automatic logic [9:0] port_mask(input int p);
		logic [9:0] m;
		m = '0;
		for (int b = 0; b < iopa_pkg::PORT_W_MAX; b++) begin
			if (b < port_width(p)) begin
				m[b] = 1'b1;
			end
		end
		return m;
	endfunction

	// True for the two pins that debug routing can own.
	function automatic logic is_dbg_pin(input int i);
		return (i == iopa_pkg::DBG_CLK_PIN) || (i == iopa_pkg::DBG_DATA_PIN);
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			localparam int PRT  = pin_port(gi);
			localparam int PBIT = gi - iopa_pkg::port_base(PRT);
			assign cell_gpio[gi] = r.odata[PRT][PBIT];
			iopa_pin_cell u_cell (
				.mode_i        (r.mode[gi]),
				.gpio_out_i    (cell_gpio[gi]),
				.periph_out_i  (periph_out_i),
				.adc_capable_i ((gi < iopa_pkg::NADC) ? 1'b1 : 1'b0),
				.drive_o       (cell_drive[gi]),
				.oe_o          (cell_oe[gi]),
				.pu_o          (cell_pu[gi]),
				.pd_o          (cell_pd[gi]),
				.ana_o         (cell_ana[gi])
			);
		end
	endgenerate

	always_comb begin
		logic [NPIN-1:0] lvl;
		logic [31:0]     rd_word;
		logic [9:0]      pw_mask;
		logic [3:0]      qs;
		logic [4:0]      qcode;
		int              idx;
		int              prt;
		int              pa;
		int              pb;
		lvl     = r.sync2;
		rd_word = '0;
		pw_mask = '0;
		qs      = '0;
		qcode   = '0;
		idx     = 0;
		prt     = 0;
		pa      = 0;
		pb      = 0;
		next_r  = r;

		// Two flops on the pad levels before any logic reads them.
		next_r.sync1 = pad_in_i;
		next_r.sync2 = r.sync1;

		idx = int'(addr_i[7:2]);
		prt = int'(addr_i[5:4]);
		pw_mask = port_mask(prt);

		// Bits beyond the width of a port are dropped on write.
		if (wr_i) begin
			if (is_mode_addr(addr_i)) begin
				next_r.mode[idx] = wdata_i[9:0] & iopa_pkg::MODE_MASK;
			end else if (is_port_addr(addr_i)) begin
				unique case (addr_i[3:0])
					iopa_pkg::DATA_OFS: next_r.odata[prt] = wdata_i[9:0] & pw_mask;
					iopa_pkg::SET_OFS:  next_r.odata[prt] = r.odata[prt] | (wdata_i[9:0] & pw_mask);
					iopa_pkg::CLR_OFS:  next_r.odata[prt] = r.odata[prt] & ~(wdata_i[9:0] & pw_mask);
					default: ;
				endcase
			end else if (addr_i == iopa_pkg::CTRL_ADDR) begin
				next_r.dbg_en  = wdata_i[iopa_pkg::CTRL_DBG_BIT];
				next_r.hold_en = wdata_i[iopa_pkg::CTRL_HOLD_BIT];
			end else if (addr_i == iopa_pkg::QUAD_ADDR) begin
				next_r.qsel = wdata_i[11:0];
			end
		end

		// Unmapped, set and clear addresses read as zero.
		if (rd_i) begin
			if (is_mode_addr(addr_i)) begin
				rd_word[9:0] = r.mode[idx];
			end else if (is_port_addr(addr_i)
			             && addr_i[3:0] == iopa_pkg::DATA_OFS) begin
				for (int b = 0; b < iopa_pkg::PORT_W_MAX; b++) begin
					if (pw_mask[b]) begin
						rd_word[b] = lvl[iopa_pkg::port_base(prt) + b]
						             & ~cell_ana[iopa_pkg::port_base(prt) + b];
					end
				end
			end else if (addr_i == iopa_pkg::CTRL_ADDR) begin
				rd_word[iopa_pkg::CTRL_DBG_BIT]  = r.dbg_en;
				rd_word[iopa_pkg::CTRL_HOLD_BIT] = r.hold_en;
			end else if (addr_i == iopa_pkg::QUAD_ADDR) begin
				rd_word[11:0] = r.qsel;
			end
		end
		next_r.rdata = rd_word;

		if (!(r.hold_en && sleep_i)) begin
			next_r.pad_out = cell_drive;
			next_r.pad_oe  = cell_oe;
			next_r.pu      = cell_pu;
			next_r.pd      = cell_pd;
			next_r.ana     = cell_ana;
			if (r.dbg_en) begin
				next_r.pad_oe[iopa_pkg::DBG_CLK_PIN]   = 1'b0;
				next_r.pu[iopa_pkg::DBG_CLK_PIN]       = 1'b0;
				next_r.pd[iopa_pkg::DBG_CLK_PIN]       = 1'b0;
				next_r.pad_out[iopa_pkg::DBG_DATA_PIN] = debug_data_out_i;
				next_r.pad_oe[iopa_pkg::DBG_DATA_PIN]  = debug_data_oe_i;
				next_r.pu[iopa_pkg::DBG_DATA_PIN]      = 1'b0;
				next_r.pd[iopa_pkg::DBG_DATA_PIN]      = 1'b0;
			end
		end
		next_r.dbg_clk = r.dbg_en & lvl[iopa_pkg::DBG_CLK_PIN];
		next_r.dbg_din = r.dbg_en & lvl[iopa_pkg::DBG_DATA_PIN];

		next_r.pin_in = '0;
		for (int c = 1; c < iopa_pkg::NCODE; c++) begin
			for (int i = NPIN - 1; i >= 0; i--) begin
				if (r.mode[i][4:0] == 5'(c) && !cell_ana[i]
				    && !(r.dbg_en && is_dbg_pin(i))) begin
					next_r.pin_in[c] = lvl[i];
				end
			end
		end

		for (int ch = 0; ch < iopa_pkg::NQCH; ch++) begin
			qs    = r.qsel[ch*iopa_pkg::QSEL_W +: iopa_pkg::QSEL_W];
			qcode = iopa_pkg::PID_QD_BASE + 5'(2 * ch);
			if (qs != 4'h0 && int'(qs) <= iopa_pkg::NQPAIR) begin
				pa = iopa_pkg::qd_pin_a(int'(qs));
				pb = iopa_pkg::qd_pin_b(int'(qs));
				next_r.qa[ch] = lvl[pa];
				next_r.qb[ch] = lvl[pb];
			end else begin
				next_r.qa[ch] = next_r.pin_in[qcode];
				next_r.qb[ch] = next_r.pin_in[qcode + 5'h01];
			end
		end
	end

	// Synchronous reset; debug routing comes up enabled.
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			r         <= '0;
			r.dbg_en  <= iopa_pkg::DBG_EN_RST;
			r.hold_en <= iopa_pkg::HOLD_EN_RST;
		end else begin
			r <= next_r;
		end
	end

	assign rdata_o              = r.rdata;
	assign pad_out_o            = r.pad_out;
	assign pad_oe_o             = r.pad_oe;
	assign pull_up_o            = r.pu;
	assign pull_down_o          = r.pd;
	assign analog_en_o          = r.ana;
	assign periph_in_o          = r.pin_in;
	assign debug_serial_clock_o = r.dbg_clk;
	assign debug_data_in_o      = r.dbg_din;
	assign quad_a_o             = r.qa;
	assign quad_b_o             = r.qb;

endmodule

//--- verilog/iopa_pkg.sv
// Constants, register map and field layout of the I/O port pin multiplexer.
// Assumes a 32-bit register port with a 12-bit byte address.
package iopa_pkg;

	localparam int NPORT      = 4;
	localparam int PORT0_W    = 8;
	localparam int PORT1_W    = 6;
	localparam int PORT2_W    = 10;
	localparam int PORT3_W    = 8;
	localparam int PORT_W_MAX = 10;
	localparam int NPIN_MAX   = 32;
	localparam int NCODE      = 32;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int MODE_W = 10;

	localparam logic [11:0] MODE_BASE   = 12'h000;
	localparam logic [11:0] PORT_BASE   = 12'h100;
	localparam logic [3:0]  DATA_OFS    = 4'h0;
	localparam logic [3:0]  SET_OFS     = 4'h4;
	localparam logic [3:0]  CLR_OFS     = 4'h8;
	localparam logic [11:0] CTRL_ADDR   = 12'h200;
	localparam logic [11:0] QUAD_ADDR   = 12'h204;

	localparam int CODE_LSB = 0;
	localparam int CODE_W   = 5;
	localparam int DIR_LSB  = 8;
	localparam int DIR_W    = 2;
	localparam logic [9:0] MODE_MASK = 10'h31F;
	localparam logic [9:0] MODE_RST  = 10'h000;

	localparam int CTRL_DBG_BIT  = 0;
	localparam int CTRL_HOLD_BIT = 1;
	localparam logic DBG_EN_RST  = 1'b1;
	localparam logic HOLD_EN_RST = 1'b0;

	localparam int QSEL_W = 4;
	localparam int NQCH   = 3;
	localparam int NQPAIR = 8;

	localparam logic [4:0] PID_GPIO    = 5'h00;
	localparam logic [4:0] PID_ADC     = 5'h1F;
	localparam logic [4:0] PID_QD_BASE = 5'h19;

	localparam int DBG_CLK_PIN  = 12;
	localparam int DBG_DATA_PIN = 13;
	localparam int NADC         = 4;

	typedef enum logic [1:0] {
		IOPA_IN_FLOAT = 2'b00,
		IOPA_IN_PU    = 2'b01,
		IOPA_IN_PD    = 2'b10,
		IOPA_OUT      = 2'b11
	} iopa_dir_t;

	function automatic int port_base(input int p);
		case (p)
			0:       return 0;
			1:       return PORT0_W;
			2:       return PORT0_W + PORT1_W;
			default: return PORT0_W + PORT1_W + PORT2_W;
		endcase
	endfunction

	function automatic int qd_pin_a(input int k);
		return (k == NQPAIR) ? port_base(2) : 2 * (k - 1);
	endfunction

	function automatic int qd_pin_b(input int k);
		return (k == NQPAIR) ? port_base(2) + 9 : 2 * (k - 1) + 1;
	endfunction

endpackage

//--- verilog/iopa_pin_cell.sv
// One pin of the multiplexer: drive value, direction, pulls and analog mode.
// Assumes mode, port data and peripheral outputs come from the same clock.
`timescale 1ns/1ps
module iopa_pin_cell (
	input  wire logic [9:0]  mode_i,
	input  wire logic        gpio_out_i,
	input  wire logic [31:0] periph_out_i,
	input  wire logic        adc_capable_i,
	output logic             drive_o,
	output logic             oe_o,
	output logic             pu_o,
	output logic             pd_o,
	output logic             ana_o
);
	logic [4:0] code;
	logic [1:0] dir;

	assign code = mode_i[iopa_pkg::CODE_LSB +: iopa_pkg::CODE_W];
	assign dir  = mode_i[iopa_pkg::DIR_LSB +: iopa_pkg::DIR_W];

	assign ana_o = adc_capable_i && (code == iopa_pkg::PID_ADC);

	assign drive_o = (code == iopa_pkg::PID_GPIO) ? gpio_out_i : periph_out_i[code];

	assign oe_o = (dir == iopa_pkg::IOPA_OUT) && !ana_o;
	assign pu_o = (dir == iopa_pkg::IOPA_IN_PU) && !ana_o;
	assign pd_o = (dir == iopa_pkg::IOPA_IN_PD) && !ana_o;

endmodule

//--- test/iopa_top_sva.sv
// Port assertions for the I/O port pin multiplexer.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module iopa_top_sva #(
	parameter int P3_W = iopa_pkg::PORT3_W
) (
	input wire logic               clk_sys_i,
	input wire logic               sys_rst_i,
	input wire logic [11:0]        addr_i,
	input wire logic               rd_i,
	input wire logic [31:0]        rdata_o,
	input wire logic [24+P3_W-1:0] pad_in_i,
	input wire logic [24+P3_W-1:0] pad_oe_o,
	input wire logic [24+P3_W-1:0] pull_up_o,
	input wire logic [24+P3_W-1:0] pull_down_o,
	input wire logic [24+P3_W-1:0] analog_en_o,
	input wire logic [31:0]        periph_in_o
);
	logic [7:0] p0_in;
	logic [3:0] ana;
	assign p0_in = pad_in_i[7:0];
	assign ana = analog_en_o[3:0];
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data not zero outside a read answer");
	a_pull_excl: assert property ((pull_up_o & pull_down_o) == '0)
		else $error("pull-up and pull-down both on");
	a_pull_forced_off: assert property (((pad_oe_o | analog_en_o) & (pull_up_o | pull_down_o)) == '0)
		else $error("pull on in output or analog mode");
	a_analog_pins: assert property ((analog_en_o & pad_oe_o) == '0 && analog_en_o[24+P3_W-1:4] == '0)
		else $error("analog mode on a wrong pin or driven");
	a_code_zero: assert property (periph_in_o[0] == 1'b0)
		else $error("peripheral input zero not low");
	a_setclr_wo: assert property (rd_i && addr_i[11:8] == 4'h1 && addr_i[3:0] != 4'h0 |=> rdata_o == 32'h0)
		else $error("set or clear register reads nonzero");
	a_analog_read: assert property (rd_i && addr_i == 12'h100 |=> (rdata_o[3:0] & $past(ana)) == 4'h0)
		else $error("analog pin reads nonzero");
	a_level_read: assert property (rd_i && addr_i == 12'h100 && ana == 4'h0 |=> rdata_o == {24'h0, $past(p0_in, 3)})
		else $error("port 0 read differs from pin levels");
	c_port_read: cover property (rd_i && addr_i == 12'h100);
	c_analog: cover property (analog_en_o[0]);
	c_shared: cover property (periph_in_o[5]);
endmodule
bind iopa_top iopa_top_sva #(.P3_W(P3_W)) i_iopa_top_sva (
	.clk_sys_i  (clk_sys_i),
	.sys_rst_i  (sys_rst_i),
	.addr_i     (addr_i),
	.rd_i       (rd_i),
	.rdata_o    (rdata_o),
	.pad_in_i   (pad_in_i),
	.pad_oe_o   (pad_oe_o),
	.pull_up_o  (pull_up_o),
	.pull_down_o(pull_down_o),
	.analog_en_o(analog_en_o),
	.periph_in_o(periph_in_o)
);

//--- test/iopa_pad_model.sv
// Package pins: device drive, outside drivers, pulls, and floating lines.
// Assumes outside drivers never fight a pin that the device drives.
`timescale 1ns/1ps
module iopa_pad_model (
	input  wire logic        clk_i,
	input  wire logic [31:0] out_i,
	input  wire logic [31:0] oe_i,
	input  wire logic [31:0] pu_i,
	input  wire logic [31:0] pd_i,
	input  wire logic [31:0] ext_i,
	input  wire logic [31:0] ext_en_i,
	output logic      [31:0] level_o
);
	logic [31:0] drift = 32'h0;
	// A floating pin changes every cycle so no stale level passes.
	always @(posedge clk_i) drift <= ~drift;
	always_comb level_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
		| (~oe_i & ~ext_en_i & (pu_i | (~pd_i & drift)));
endmodule

//--- test/iopa_top_bench.sv
// Self-checking bench for the I/O port pin multiplexer.
// Assumes the package, the design and the pad model are compiled first.
`timescale 1ns/1ps
module iopa_top_bench;
	logic        clk_sys_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [11:0] addr_i = 12'h000;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        sleep_i = 1'b0;
	logic        dbg_dout = 1'b0;
	logic        dbg_doe = 1'b0;
	logic [31:0] periph_out_i = 32'h0;
	logic [31:0] ext_val = 32'h0;
	logic [31:0] ext_en = 32'h0;
	logic [31:0] rdata_o, pad_in_i, pad_out_o, pad_oe_o, pull_up_o, pull_down_o;
	logic [31:0] analog_en_o, periph_in_o, q;
	logic        dbg_clk, dbg_in;
	logic [2:0]  quad_a, quad_b;
	int          err_total = 0;
	int          comparisons = 0;
	always #2 clk_sys_i = ~clk_sys_i;
	iopa_top i_iopa_top (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pad_in_i(pad_in_i),
		.pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pull_up_o(pull_up_o),
		.pull_down_o(pull_down_o), .analog_en_o(analog_en_o), .periph_out_i(periph_out_i),
		.periph_in_o(periph_in_o), .sleep_i(sleep_i), .debug_data_out_i(dbg_dout),
		.debug_data_oe_i(dbg_doe), .debug_serial_clock_o(dbg_clk), .debug_data_in_o(dbg_in),
		.quad_a_o(quad_a), .quad_b_o(quad_b));
	iopa_pad_model i_iopa_pad_model (.clk_i(clk_sys_i), .out_i(pad_out_o), .oe_i(pad_oe_o),
		.pu_i(pull_up_o), .pd_i(pull_down_o), .ext_i(ext_val), .ext_en_i(ext_en),
		.level_o(pad_in_i));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk_sys_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		q = rdata_o;
	endtask
	task automatic t_dir;
		logic [2:0] e [4] = '{3'b000, 3'b010, 3'b001, 3'b100};
		wr(12'h050, 32'hFFFFFFFF);
		rd(12'h050);
		chk(q, 32'h31F);
		rd(12'h124);
		chk(q, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(12'h050, {22'h0, 2'(k), 8'h00});
			tick(2);
			chk({pad_oe_o[20], pull_up_o[20], pull_down_o[20]}, e[k]);
		end
		$display("t_dir done");
	endtask
	task automatic t_gpio;
		logic [11:0] a [5] = '{12'h120, 12'h124, 12'h128, 12'h124, 12'h128};
		logic [9:0]  d [5] = '{10'h040, 10'h001, 10'h040, 10'h000, 10'h000};
		logic [1:0]  e [5] = '{2'b10, 2'b11, 2'b01, 2'b01, 2'b01};
		wr(12'h038, 32'h300);
		for (int k = 0; k < 5; k++) begin
			wr(a[k], {22'h0, d[k]});
			tick(2);
			chk({pad_out_o[20], pad_out_o[14]}, e[k]);
		end
		rd(12'h120);
		chk(q & 32'h41, 32'h01);
		$display("t_gpio done");
	endtask
	task automatic t_share;
		wr(12'h054, 32'h005);
		wr(12'h058, 32'h005);
		ext_en <= 32'h0060_0000;
		ext_val <= 32'h0020_0000;
		tick(4);
		chk(periph_in_o[5], 1'b1);
		ext_val <= 32'h0040_0000;
		tick(4);
		chk(periph_in_o[5], 1'b0);
		wr(12'h03C, 32'h306);
		wr(12'h040, 32'h306);
		periph_out_i <= 32'h40;
		tick(2);
		chk(pad_out_o[16:15], 2'b11);
		wr(12'h040, 32'h300);
		periph_out_i <= 32'h0;
		tick(2);
		chk(pad_out_o[16:15], 2'b00);
		$display("t_share done");
	endtask
	task automatic t_analog;
		ext_en <= 32'h1003;
		ext_val <= 32'h1001;
		wr(12'h000, 32'h11F);
		wr(12'h014, 32'h01F);
		tick(3);
		chk({analog_en_o[0], pull_up_o[0], pad_oe_o[0], analog_en_o[5]}, 4'h8);
		rd(12'h100);
		chk(q[0], 1'b0);
		wr(12'h000, 32'h000);
		tick(3);
		rd(12'h100);
		chk(q[0], 1'b1);
		$display("t_analog done");
	endtask
	task automatic t_fixed;
		chk(dbg_clk, 1'b1);
		dbg_doe <= 1'b1;
		dbg_dout <= 1'b1;
		tick(5);
		chk({pad_oe_o[13], pad_out_o[13], pull_up_o[13], dbg_in}, 4'b1101);
		wr(12'h204, 32'h001);
		tick(4);
		chk({quad_b[0], quad_a[0]}, 2'b01);
		wr(12'h200, 32'h002);
		tick(3);
		chk(dbg_clk, 1'b0);
		sleep_i <= 1'b1;
		wr(12'h124, 32'h040);
		tick(3);
		chk(pad_out_o[20], 1'b0);
		sleep_i <= 1'b0;
		tick(3);
		chk(pad_out_o[20], 1'b1);
		$display("t_fixed done");
	endtask
	task automatic tally_and_finish;
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		tick(3);
		t_dir;
		t_gpio;
		t_share;
		t_analog;
		t_fixed;
		tally_and_finish;
	end
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		err_total++;
		tally_and_finish;
	end
endmodule
